// >>> host_port_params.svh
// Constants for the processor-side bus port of the serial interface
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// Status byte bit positions
`define ST_TX_REQ_BIT      3'd0
`define ST_RX_AVAIL_BIT    3'd1
`define ST_TX_DRAINED_BIT  3'd2
`define ST_PARITY_BIT      3'd3
`define ST_OVERRUN_BIT     3'd4
`define ST_FRAMING_BIT     3'd5
`define ST_SYNC_BIT        3'd6
`define ST_MODEM_READY_BIT 3'd7

// Mode word fields
`define MODE_CLOCK_LSB     3'd0
`define MODE_SYNC_CODE     2'h0
`define MODE_EXT_SYNC_BIT  3'd6

// Command word fields
`define CMD_TX_ENABLE_BIT  3'd0
`define CMD_ERR_RESET_BIT  3'd4
`define CMD_SOFT_RESET_BIT 3'd6

// Reset values
`define MODE_RESET         8'h00
`define CMD_RESET          8'h00
`define DATA_RESET         8'h00

// Timing, system_clock_period in ns
`define SYSTEM_CLOCK_PERIOD_NS 5
`define RESET_MIN_PERIODS      6

`endif

// >>> host_port_pkg.sv
// Types for the processor-side bus port of the serial interface
package host_port_pkg;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       cd;
    logic [7:0] data;
    logic       modem_ready_n;
    logic       sync_pin;
  } host_pins_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WRITE,
    ACC_READ,
    ACC_INVALID
  } access_state_t;

  typedef struct packed {
    host_pins_t    pin1;
    host_pins_t    pin2;
    access_state_t st;
    logic          cd;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    logic          oe_n;
    logic [7:0]    mode;
    logic [7:0]    cmd;
    logic          configured;
    logic          expect_mode;
    logic [7:0]    tx_hold;
    logic          tx_full;
    logic [7:0]    rx_buf;
    logic          rx_full;
    logic          parity_err;
    logic          overrun_err;
    logic          framing_err;
    logic          sync_hit;
  } port_state_t;

  localparam host_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cd: 1'b0,
                                       data: 8'h00, modem_ready_n: 1'b1, sync_pin: 1'b0};

endpackage

// >>> usart_host_bus_interface.sv
// Processor-side bus port and read/write control of the serial interface
//
// Summary of operation
// - Reset forces idle until mode word rewritten
// - Clock times internal logic; pins are synchronised
// - Write strobe low loads bus contents
// - Read strobe low drives requested byte
// - Control/data line selects control or data
// - Strobes ignored unless chip select low
// - Data bus driven only during selected read
// - Control, command, status share the data bus
// - Mode and command words stored until rewritten
// - Flags for transmit space and received char
// - Full status byte readable at any time
// - Data write clears transmit request
// - Data read clears receive available
// - Status read clears internal sync flag
// - Modem-ready input visible in status
`timescale 1ns/100ps
`include "host_port_params.svh"

module usart_host_bus_interface (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Processor bus pins
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_cd,
  input  wire logic [7:0] i_host_data_bus,
  output logic      [7:0] o_host_data_bus,
  output logic            o_host_data_bus_oe_n,
  // Device pins
  input  wire logic       i_modem_ready_n,
  input  wire logic       i_sync_found_pin,
  output logic            o_sync_found_flag,
  output logic            o_sync_found_oe_n,
  output logic            o_tx_char_request,
  output logic            o_rx_char_available,
  output logic            o_tx_drained_flag,
  // Serial engine side, same clock
  output logic      [7:0] o_mode_word,
  output logic      [7:0] o_command_word,
  output logic            o_configured,
  output logic      [7:0] o_tx_char,
  output logic            o_tx_hold_full,
  input  wire logic       i_tx_take,
  input  wire logic       i_tx_idle,
  input  wire logic [7:0] i_rx_char,
  input  wire logic       i_rx_char_valid,
  input  wire logic       i_parity_error,
  input  wire logic       i_framing_error,
  input  wire logic       i_sync_hit
);

  host_port_pkg::port_state_t q;
  host_port_pkg::port_state_t d;
  host_port_pkg::host_pins_t  pins_in;
  host_port_pkg::host_pins_t  p;

  logic sel;
  logic wr_commit;
  logic rd_done;
  logic sync_mode;
  logic ext_sync;
  logic tx_req;
  logic drained;
  logic sync_val;

  function automatic logic [7:0] status_byte(
    input host_port_pkg::port_state_t s,
    input logic                       req,
    input logic                       drn,
    input logic                       syn
  );
    logic [7:0] b;
    b = 8'h00;
    b[`ST_TX_REQ_BIT]      = req;
    b[`ST_RX_AVAIL_BIT]    = s.rx_full;
    b[`ST_TX_DRAINED_BIT]  = drn;
    b[`ST_PARITY_BIT]      = s.parity_err;
    b[`ST_OVERRUN_BIT]     = s.overrun_err;
    b[`ST_FRAMING_BIT]     = s.framing_err;
    b[`ST_SYNC_BIT]        = syn;
    b[`ST_MODEM_READY_BIT] = ~s.pin2.modem_ready_n;
    return b;
  endfunction

  // Every pin is re-timed by two flops, so nothing outside is referenced to i_clk
  assign pins_in = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n, cd: i_cd,
                     data: i_host_data_bus, modem_ready_n: i_modem_ready_n,
                     sync_pin: i_sync_found_pin};
  assign p       = q.pin2;
  assign sel     = ~p.cs_n;

  assign sync_mode = (q.mode[`MODE_CLOCK_LSB +: 2] == `MODE_SYNC_CODE) && q.configured;
  assign ext_sync  = sync_mode && q.mode[`MODE_EXT_SYNC_BIT];
  assign sync_val  = ext_sync ? p.sync_pin : q.sync_hit;
  assign tx_req    = q.configured && !q.tx_full && q.cmd[`CMD_TX_ENABLE_BIT];
  assign drained   = q.configured && !q.tx_full && i_tx_idle;

  always_comb begin
    d         = q;
    wr_commit = 1'b0;
    rd_done   = 1'b0;
    d.pin1    = pins_in;
    d.pin2    = q.pin1;

    unique case (q.st)
      host_port_pkg::ACC_IDLE: begin
        if (sel && !p.rd_n && !p.wr_n) begin
          d.st = host_port_pkg::ACC_INVALID;
        end else if (sel && !p.wr_n) begin
          d.st    = host_port_pkg::ACC_WRITE;
          d.cd    = p.cd;
          d.wdata = p.data;
        end else if (sel && !p.rd_n) begin
          d.st    = host_port_pkg::ACC_READ;
          d.cd    = p.cd;
          // Status and received data share one bus
          d.rdata = p.cd ? status_byte(q, tx_req, drained, sync_val) : q.rx_buf;
          d.oe_n  = 1'b0;
        end
      end
      host_port_pkg::ACC_WRITE: begin
        if (!sel) begin
          // Deselect before the strobe ends aborts the write
          d.st = host_port_pkg::ACC_IDLE;
        end else if (!p.rd_n) begin
          d.st = host_port_pkg::ACC_INVALID;
        end else if (!p.wr_n) begin
          d.wdata = p.data;
        end else begin
          // Data is taken at the trailing edge, where the bus is surely settled
          wr_commit = 1'b1;
          d.st      = host_port_pkg::ACC_IDLE;
        end
      end
      host_port_pkg::ACC_READ: begin
        if (!p.wr_n) begin
          d.st   = host_port_pkg::ACC_INVALID;
          d.oe_n = 1'b1;
        end else if (!sel) begin
          d.st   = host_port_pkg::ACC_IDLE;
          d.oe_n = 1'b1;
        end else if (p.rd_n) begin
          rd_done = 1'b1;
          d.st    = host_port_pkg::ACC_IDLE;
          d.oe_n  = 1'b1;
        end
      end
      host_port_pkg::ACC_INVALID: begin
        d.oe_n = 1'b1;
        if (!sel || (p.rd_n && p.wr_n)) begin
          d.st = host_port_pkg::ACC_IDLE;
        end
      end
    endcase

    // Clears come first so set events in the same cycle win
    if (i_tx_take) begin
      d.tx_full = 1'b0;
    end
    if (rd_done && !q.cd) begin
      d.rx_full = 1'b0;
    end
    if (rd_done && q.cd) begin
      d.sync_hit = 1'b0;
    end

    if (wr_commit && !q.cd) begin
      d.tx_hold = q.wdata;
      d.tx_full = 1'b1;
    end
    if (wr_commit && q.cd) begin
      if (q.expect_mode) begin
        d.mode        = q.wdata;
        d.expect_mode = 1'b0;
        d.configured  = 1'b1;
      end else if (q.wdata[`CMD_SOFT_RESET_BIT]) begin
        // Soft reset leaves the port waiting for a fresh mode word
        d.cmd         = `CMD_RESET;
        d.expect_mode = 1'b1;
        d.configured  = 1'b0;
        d.tx_full     = 1'b0;
        d.rx_full     = 1'b0;
      end else begin
        d.cmd = q.wdata;
        if (q.wdata[`CMD_ERR_RESET_BIT]) begin
          d.parity_err  = 1'b0;
          d.overrun_err = 1'b0;
          d.framing_err = 1'b0;
        end
      end
    end

    if (i_rx_char_valid) begin
      if (q.rx_full && !(rd_done && !q.cd)) begin
        d.overrun_err = 1'b1;
      end
      d.rx_buf  = i_rx_char;
      d.rx_full = 1'b1;
    end
    if (i_parity_error) begin
      d.parity_err = 1'b1;
    end
    if (i_framing_error) begin
      d.framing_err = 1'b1;
    end
    if (i_sync_hit && sync_mode && !ext_sync) begin
      d.sync_hit = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q             <= '0;
      q.pin1        <= host_port_pkg::PINS_IDLE;
      q.pin2        <= host_port_pkg::PINS_IDLE;
      q.oe_n        <= 1'b1;
      q.expect_mode <= 1'b1;
      q.mode        <= `MODE_RESET;
      q.cmd         <= `CMD_RESET;
      q.rdata       <= `DATA_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_host_data_bus      = q.rdata;
  assign o_host_data_bus_oe_n = q.oe_n;
  assign o_sync_found_flag    = q.sync_hit;
  assign o_sync_found_oe_n    = !(sync_mode && !ext_sync);
  assign o_tx_char_request    = tx_req;
  assign o_rx_char_available  = q.rx_full;
  assign o_tx_drained_flag    = drained;
  assign o_mode_word          = q.mode;
  assign o_command_word       = q.cmd;
  assign o_configured         = q.configured;
  assign o_tx_char            = q.tx_hold;
  assign o_tx_hold_full       = q.tx_full;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_read_start;
    q.st == host_port_pkg::ACC_IDLE && sel && !p.rd_n && p.wr_n;
  endsequence

  sequence s_status_start;
    s_read_start ##0 p.cd;
  endsequence

  sequence s_deselected;
    p.cs_n [*2];
  endsequence

  a_idle_after_reset: assert property ($rose(i_rst_n) |-> !q.configured && !o_tx_char_request)
    else $error("port not idle after reset");

  a_read_drives_bus: assert property (s_read_start |=> !o_host_data_bus_oe_n)
    else $error("selected read did not drive the bus");

  a_bus_released: assert property (s_deselected |-> ##1 o_host_data_bus_oe_n)
    else $error("bus driven while deselected");

  a_deselect_no_write: assert property (p.cs_n |=> !$rose(q.tx_full) && $stable(q.cmd))
    else $error("transfer while deselected");

  a_data_write_load: assert property (wr_commit && !q.cd |=> q.tx_hold == $past(q.wdata))
    else $error("data character not loaded");

  a_mode_store: assert property (wr_commit && q.cd && q.expect_mode
      |=> q.mode == $past(q.wdata) && !q.expect_mode && q.configured)
    else $error("mode word not stored");

  a_tx_req_clear: assert property (wr_commit && !q.cd |=> !o_tx_char_request)
    else $error("transmit request not cleared by data write");

  a_rx_avail_clear: assert property (rd_done && !q.cd && !i_rx_char_valid
      |=> !o_rx_char_available)
    else $error("receive available not cleared by data read");

  a_sync_clear: assert property (rd_done && q.cd && !i_sync_hit |=> !o_sync_found_flag)
    else $error("sync flag not cleared by status read");

  a_modem_status: assert property (s_status_start
      |=> o_host_data_bus[`ST_MODEM_READY_BIT] == !$past(p.modem_ready_n))
    else $error("modem ready missing from status");

  a_invalid_quiet: assert property (q.st == host_port_pkg::ACC_INVALID
      |=> o_host_data_bus_oe_n && $stable(q.mode) && $stable(q.cmd) && !$rose(q.tx_full))
    else $error("invalid access changed state");

  a_rx_avail_set: assert property (i_rx_char_valid |=> o_rx_char_available)
    else $error("receive available not raised by new character");

  a_soft_reset: assert property (wr_commit && q.cd && !q.expect_mode
      && q.wdata[`CMD_SOFT_RESET_BIT]
      |=> !o_configured && !o_tx_char_request && o_command_word == `CMD_RESET)
    else $error("soft reset did not return port to idle");

endmodule

// >>> cpu_bus_model.sv
// Processor bus model that drives the host port pins
`timescale 1ns/100ps
module cpu_bus_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_bus,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_cd,
  output logic            o_drive,
  output logic      [7:0] o_data
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_cd, o_drive} = 5'h1c;
    o_data = 8'h00;
  end
  // Strobes are held 5 clocks, longer than the synchroniser needs, and data is kept
  // 3 clocks past the strobe so that a late commit still sees it
  task automatic access(input logic cs_n, input logic rd_n, input logic wr_n,
                        input logic cd, input logic [7:0] wd, output logic [7:0] rv);
    @(posedge i_clk);
    o_cs_n <= cs_n;
    o_cd <= cd;
    o_data <= wd;
    o_drive <= !wr_n;
    @(posedge i_clk);
    o_rd_n <= rd_n;
    o_wr_n <= wr_n;
    repeat (5) @(posedge i_clk);
    rv = i_bus;
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_drive <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// >>> usart_host_bus_interface_tb.sv
// Self-checking bench for the processor-side host port
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module usart_host_bus_interface_tb;
  typedef struct packed {
    logic [4:0] ev;
    logic       wr;
    logic       cd;
    logic [7:0] d;
    logic [7:0] st;
  } row_t;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic       cs_n, rd_n, wr_n, cd, drive, dev_oe_n, sync_flag, sync_oe_n, tx_req, configured;
  logic       tx_take, rx_valid, par_err, frm_err, sync_hit, modem_n;
  logic       rx_avail, drained, hold_full, sync_pin = 1'b0, tx_idle = 1'b1;
  logic [7:0] cpu_d, dev_d, bus, rx_char, mode_w, cmd_w, tx_char, rv;
  int         n_mismatch = 0, comparisons = 0, n_drive = 0, cyc = 0;
  row_t       rows [9] = '{
    '{5'h00, 1'b0, 1'b1, 8'h80, 8'h80}, '{5'h00, 1'b1, 1'b1, 8'h4e, 8'h84},
    '{5'h00, 1'b1, 1'b1, 8'h01, 8'h85}, '{5'h00, 1'b1, 1'b0, 8'ha5, 8'h80},
    '{5'h01, 1'b0, 1'b1, 8'h85, 8'h85}, '{5'h02, 1'b0, 1'b1, 8'h87, 8'h87},
    '{5'h00, 1'b0, 1'b0, 8'h87, 8'h85}, '{5'h0c, 1'b0, 1'b1, 8'had, 8'had},
    '{5'h00, 1'b1, 1'b1, 8'h11, 8'h85}};

  // Runs far above any serial clock the engine will meet
  always #2.5 clk = ~clk;
  // A released bus shows the inverse of its last level, so stale data cannot pass
  assign bus = !dev_oe_n ? dev_d : drive ? cpu_d : ~last_q;

  always @(posedge clk) begin
    last_q <= bus;
    cyc <= cyc + 1;
    if (!dev_oe_n)
      n_drive <= n_drive + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  cpu_bus_model cpu_u (.i_clk(clk), .i_bus(bus), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
                       .o_cd(cd), .o_drive(drive), .o_data(cpu_d));

  usart_host_bus_interface dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_cd(cd),
    .i_host_data_bus(bus), .o_host_data_bus(dev_d), .o_host_data_bus_oe_n(dev_oe_n),
    .i_modem_ready_n(modem_n), .i_sync_found_pin(sync_pin), .o_sync_found_flag(sync_flag),
    .o_sync_found_oe_n(sync_oe_n), .o_tx_char_request(tx_req),
    .o_rx_char_available(rx_avail), .o_tx_drained_flag(drained), .o_mode_word(mode_w),
    .o_command_word(cmd_w), .o_configured(configured), .o_tx_char(tx_char),
    .o_tx_hold_full(hold_full), .i_tx_take(tx_take),
    .i_tx_idle(tx_idle), .i_rx_char(rx_char), .i_rx_char_valid(rx_valid),
    .i_parity_error(par_err), .i_framing_error(frm_err), .i_sync_hit(sync_hit));

  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic c, input logic [7:0] d);
    cpu_u.access(1'b0, 1'b1, 1'b0, c, d, rv);
  endtask

  task automatic rd(input logic c);
    cpu_u.access(1'b0, 1'b0, 1'b1, c, 8'h00, rv);
  endtask

  task automatic pulse(input logic [4:0] ev);
    @(posedge clk);
    {sync_hit, frm_err, par_err, rx_valid, tx_take} <= ev;
    @(posedge clk);
    {sync_hit, frm_err, par_err, rx_valid, tx_take} <= 5'h00;
    // Flags launched at the last edge are only settled one edge later
    @(posedge clk);
  endtask

  initial begin
    {tx_take, rx_valid, par_err, frm_err, sync_hit, modem_n} = 6'h00;
    rx_char = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rx_char <= rows[i].d;
      if (rows[i].ev != 5'h00)
        pulse(rows[i].ev);
      if (rows[i].wr)
        wr(rows[i].cd, rows[i].d);
      else begin
        rd(rows[i].cd);
        `CHK(rv, rows[i].d)
      end
      rd(1'b1);
      `CHK(rv, rows[i].st)
      `CHK({drained, rx_avail, tx_req}, rows[i].st[2:0])
      if (rows[i].wr && !rows[i].cd)
        `CHK(hold_full, 1'b1)
      $display("Row %0d done", i);
    end
    `CHK(mode_w, 8'h4e)
    `CHK(cmd_w, 8'h11)
    `CHK(tx_char, 8'ha5)
    modem_n <= 1'b1;
    rd(1'b1);
    `CHK(rv, 8'h05)
    modem_n <= 1'b0;
    $display("Stored words and modem status done");
    n_drive = 0;
    cpu_u.access(1'b1, 1'b1, 1'b0, 1'b1, 8'h40, rv);
    cpu_u.access(1'b1, 1'b0, 1'b1, 1'b1, 8'h00, rv);
    `CHK(cmd_w, 8'h11)
    cpu_u.access(1'b0, 1'b0, 1'b0, 1'b1, 8'h40, rv);
    `CHK(cmd_w, 8'h11)
    `CHK(n_drive, 0)
    rd(1'b1);
    `CHK(n_drive > 0, 1'b1)
    $display("Deselected and invalid access done");
    wr(1'b1, 8'h40);
    `CHK(configured, 1'b0)
    `CHK(tx_req, 1'b0)
    wr(1'b1, 8'h00);
    `CHK(configured, 1'b1)
    wr(1'b1, 8'h01);
    pulse(5'h10);
    `CHK(sync_flag, 1'b1)
    `CHK(sync_oe_n, 1'b0)
    rd(1'b1);
    `CHK(rv[6], 1'b1)
    `CHK(sync_flag, 1'b0)
    $display("Soft reset and sync flag done");
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(cmd_w, 8'h00)
    `CHK(configured, 1'b0)
    wr(1'b1, 8'h4e);
    `CHK(mode_w, 8'h4e)
    `CHK(cmd_w, 8'h00)
    $display("Reset in mid-run done");
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h40);
    tx_idle  <= 1'b0;
    sync_pin <= 1'b1;
    pulse(5'h02);
    pulse(5'h02);
    rd(1'b1);
    `CHK(rv, 8'hd2)
    `CHK(sync_oe_n, 1'b1)
    `CHK(drained, 1'b0)
    `CHK(rx_avail, 1'b1)
    $display("External sync and overrun done");
    finish_test();
  end
endmodule
